// file: src/sbsp_regs.svh
`ifndef SBSP_REGS_SVH
`define SBSP_REGS_SVH

// ****************************************************************
// Widths of the port
// ****************************************************************
`define SBSP_ADDR_W      19
`define SBSP_HI_W        17
`define SBSP_SEED_W      2
`define SBSP_LANES       4
`define SBSP_LANE_W      9
`define SBSP_DATA_W      36
`define SBSP_SYNC_W      2

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define SBSP_SEED_RST    2'h0
`define SBSP_BEAT_ONE    2'h1
`define SBSP_HI_RST      17'h00000
`define SBSP_LANE_NONE   4'h0
`define SBSP_LANE_ALL    4'hF
`define SBSP_DATA_RST    36'h000000000
`define SBSP_SYNC_RST    2'h3
`define SBSP_OE_BIT      0
`define SBSP_MODE_BIT    1

`endif

// file: src/sbsp_pkg.sv
package sbsp_pkg;

	typedef enum logic [0:0] {
		SBSP_LINEAR      = 1'b0,
		SBSP_INTERLEAVED = 1'b1
	} sbsp_order_t;

	typedef enum logic [1:0] {
		SBSP_PH_IDLE  = 2'b00,
		SBSP_PH_READ  = 2'b01,
		SBSP_PH_FIRST = 2'b10
	} sbsp_phase_t;

endpackage

// file: src/sbsp_burst_counter.sv
`timescale 1ns/1ps
`include "sbsp_regs.svh"

module sbsp_burst_counter
	import sbsp_pkg::*;
(
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	// Control
	input  wire logic                    load,
	input  wire logic                    step,
	input  wire logic [`SBSP_SEED_W-1:0] burst_seed_bits,
	input  wire sbsp_order_t             order,
	// Result
	output logic      [`SBSP_SEED_W-1:0] low_bits
);

	logic [`SBSP_SEED_W-1:0] seed;
	logic [`SBSP_SEED_W-1:0] beat;
	logic [`SBSP_SEED_W-1:0] next_seed;
	logic [`SBSP_SEED_W-1:0] next_beat;
	logic [`SBSP_SEED_W-1:0] next_low;

	always_comb begin
		next_seed = seed;
		next_beat = beat;
		if (load) begin
			next_seed = burst_seed_bits; // RULE2
			next_beat = `SBSP_SEED_RST;
		end else if (step) begin
			next_beat = beat + `SBSP_BEAT_ONE; // RULE5 RULE15
		end
		case (order)
			SBSP_LINEAR:      next_low = next_seed + next_beat; // RULE13 RULE15
			SBSP_INTERLEAVED: next_low = next_seed ^ next_beat; // RULE13 RULE15
			default:          next_low = next_seed;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			seed     <= `SBSP_SEED_RST;
			beat     <= `SBSP_SEED_RST;
			low_bits <= `SBSP_SEED_RST;
		end else begin
			seed     <= next_seed;
			beat     <= next_beat;
			low_bits <= next_low;
		end
	end

endmodule

// file: src/sbsp_port.sv
// Contract
// RULE1 - The address is captured only on an edge where a strobe is recognised and all selects are active.
// RULE2 - The two lowest captured address bits seed a 2-bit counter that supplies the low burst address.
// RULE3 - Active-low lane write selects are sampled at the edge and act only with the byte write qualifier low.
// RULE4 - The all-bytes write sampled low writes every lane regardless of lane selects and qualifier.
// RULE5 - During a burst the counter steps on every edge where the advance input is sampled low.
// RULE6 - Every synchronous input is sampled on the rising clock edge and acts at no other time.
// RULE7 - The processor strobe is ignored whenever the first select is sampled high.
// RULE8 - The port is selected only with first select low, second select high and third select low.
// RULE9 - Selects are evaluated only on address load edges and advance cycles keep that selection.
// RULE10 - The data lines are driven while output enable is low and released while it is high.
// RULE11 - On the first read clock after a deselected state output enable is ignored and lines stay released.
// RULE12 - When both strobes are low on one edge only the processor strobe is acted on; with first select high the code acts on the controller strobe.
// RULE13 - The order strap low gives a linear burst and high gives an interleaved burst.
// RULE14 - The data lines are released during write data and while deselected whatever output enable is.
// RULE15 - The counter wraps in two bits, counting up in linear order and XOR-ing seed with beat otherwise.
`timescale 1ns/1ps
`include "sbsp_regs.svh"

module sbsp_port
	import sbsp_pkg::*;
(
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	// Address and strobes
	input  wire logic [`SBSP_ADDR_W-1:0] address,
	input  wire logic                    processor_addr_strobe_n,
	input  wire logic                    controller_addr_strobe_n,
	input  wire logic                    burst_step_n,
	// Selects
	input  wire logic                    select_low_a_n,
	input  wire logic                    select_high,
	input  wire logic                    select_low_b_n,
	// Writes
	input  wire logic [`SBSP_LANES-1:0]  byte_lane_write_n,
	input  wire logic                    byte_write_qualifier_n,
	input  wire logic                    all_bytes_write_n,
	// Asynchronous pins
	input  wire logic                    output_enable_n,
	input  wire logic                    burst_order,
	// Data lines, parity bit at the top of each lane
	input  wire logic [`SBSP_DATA_W-1:0] dq_in,
	output logic      [`SBSP_DATA_W-1:0] dq_out,
	output logic                         dq_oe,
	// Array side
	output logic      [`SBSP_ADDR_W-1:0] mem_addr,
	output logic      [`SBSP_LANES-1:0]  mem_wr_lane,
	output logic      [`SBSP_DATA_W-1:0] mem_wdata,
	input  wire logic [`SBSP_DATA_W-1:0] mem_rdata,
	output logic                         selected
);

	// ****************************************************************
	// Pin synchronisers for output enable and order strap
	// ****************************************************************
	logic [`SBSP_SYNC_W-1:0] sync_a;
	logic [`SBSP_SYNC_W-1:0] sync_b;
	logic [`SBSP_SYNC_W-1:0] sync_c;
	logic [`SBSP_SYNC_W-1:0] pin_level;
	logic [`SBSP_SYNC_W-1:0] next_pin_level;
	logic [`SBSP_SYNC_W-1:0] pin_raw;

	assign pin_raw = {burst_order, output_enable_n};

	genvar gi;
	generate
		for (gi = 0; gi < `SBSP_SYNC_W; gi = gi + 1) begin : g_pin
			always_comb begin
				next_pin_level[gi] = pin_level[gi];
				if (sync_b[gi] == sync_c[gi]) begin
					next_pin_level[gi] = sync_c[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sync_a    <= `SBSP_SYNC_RST;
			sync_b    <= `SBSP_SYNC_RST;
			sync_c    <= `SBSP_SYNC_RST;
			pin_level <= `SBSP_SYNC_RST;
		end else begin
			sync_a    <= pin_raw;
			sync_b    <= sync_a;
			sync_c    <= sync_b;
			pin_level <= next_pin_level;
		end
	end

	sbsp_order_t order;
	assign order = sbsp_order_t'(pin_level[`SBSP_MODE_BIT]);

	// ****************************************************************
	// Address load, selection and write decode
	// ****************************************************************
	logic                    proc_load;
	logic                    ctrl_load;
	logic                    load_go;
	logic                    ce_ok;
	logic                    step_go;
	logic                    next_selected;
	logic [`SBSP_HI_W-1:0]   addr_hi;
	logic [`SBSP_HI_W-1:0]   next_addr_hi;
	logic [`SBSP_LANES-1:0]  next_wr_lane;
	logic [`SBSP_DATA_W-1:0] next_wdata;
	logic                    read_beat;
	logic                    next_read_beat;
	logic                    first_beat;
	logic                    next_first_beat;
	logic [`SBSP_SEED_W-1:0] low_bits;

	always_comb begin
		ce_ok     = !select_low_a_n && select_high && !select_low_b_n; // RULE8
		proc_load = !processor_addr_strobe_n && !select_low_a_n; // RULE7
		ctrl_load = !controller_addr_strobe_n && !proc_load; // RULE12
		load_go   = proc_load || ctrl_load;
		step_go   = selected && !load_go && !burst_step_n; // RULE5
		next_selected = selected;
		next_addr_hi  = addr_hi;
		if (load_go) begin
			next_selected = ce_ok; // RULE9
			if (ce_ok) begin
				next_addr_hi = address[`SBSP_ADDR_W-1:`SBSP_SEED_W]; // RULE1
			end
		end
		if (!all_bytes_write_n) begin
			next_wr_lane = `SBSP_LANE_ALL; // RULE4
		end else if (!byte_write_qualifier_n) begin
			next_wr_lane = ~byte_lane_write_n; // RULE3
		end else begin
			next_wr_lane = `SBSP_LANE_NONE;
		end
		if (!next_selected) begin
			next_wr_lane = `SBSP_LANE_NONE;
		end
		next_wdata      = dq_in;
		next_read_beat  = next_selected && (next_wr_lane == `SBSP_LANE_NONE);
		next_first_beat = load_go && ce_ok && !selected;
	end

	always_ff @(posedge core_clk or negedge resetn) begin // RULE6
		if (!resetn) begin
			selected    <= 1'b0;
			addr_hi     <= `SBSP_HI_RST;
			mem_wr_lane <= `SBSP_LANE_NONE;
			mem_wdata   <= `SBSP_DATA_RST;
			read_beat   <= 1'b0;
			first_beat  <= 1'b0;
		end else begin
			selected    <= next_selected;
			addr_hi     <= next_addr_hi;
			mem_wr_lane <= next_wr_lane;
			mem_wdata   <= next_wdata;
			read_beat   <= next_read_beat;
			first_beat  <= next_first_beat;
		end
	end

	sbsp_burst_counter u_counter (
		.core_clk        (core_clk),
		.resetn          (resetn),
		.load            (load_go && ce_ok),
		.step            (step_go),
		.burst_seed_bits (address[`SBSP_SEED_W-1:0]),
		.order           (order),
		.low_bits        (low_bits)
	);

	assign mem_addr = {addr_hi, low_bits};

	// ****************************************************************
	// Read data phase and output drive
	// ****************************************************************
	sbsp_phase_t             phase;
	sbsp_phase_t             next_phase;
	logic [`SBSP_DATA_W-1:0] next_dq_out;

	always_comb begin
		next_dq_out = dq_out;
		case ({read_beat, first_beat})
			2'b10:   next_phase = SBSP_PH_READ;
			2'b11:   next_phase = SBSP_PH_FIRST; // RULE11
			default: next_phase = SBSP_PH_IDLE; // RULE14
		endcase
		if (read_beat) begin
			next_dq_out = mem_rdata;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			phase  <= SBSP_PH_IDLE;
			dq_out <= `SBSP_DATA_RST;
		end else begin
			phase  <= next_phase;
			dq_out <= next_dq_out;
		end
	end

	// Output enable is level sensitive apart from its pin synchroniser.
	assign dq_oe = !pin_level[`SBSP_OE_BIT] && (phase == SBSP_PH_READ); // RULE10 RULE11 RULE14

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_desel_then_read;
		!selected ##1 (selected && read_beat && first_beat);
	endsequence

	sequence s_linear_step;
		step_go && order == SBSP_LINEAR;
	endsequence

	a_addr_load_gate: assert property ( // RULE1
		(addr_hi != $past(addr_hi)) |-> $past(load_go && ce_ok))
		else $error("address changed without a qualified strobe");
	a_seed_load: assert property ( // RULE2
		(load_go && ce_ok && order == SBSP_LINEAR) ##1 (order == SBSP_LINEAR)
		|-> low_bits == $past(address[`SBSP_SEED_W-1:0]))
		else $error("counter not seeded from the low address bits");
	a_lane_qualified: assert property ( // RULE3
		all_bytes_write_n |=> !selected || mem_wr_lane == ($past(byte_write_qualifier_n)
		? `SBSP_LANE_NONE : ~$past(byte_lane_write_n)))
		else $error("lane write does not follow the lane selects");
	a_all_lanes: assert property ( // RULE4
		!all_bytes_write_n |=> !selected || mem_wr_lane == `SBSP_LANE_ALL)
		else $error("all-bytes write missed a lane");
	a_linear_step: assert property ( // RULE5
		s_linear_step ##1 (order == SBSP_LINEAR) |-> low_bits == $past(low_bits) + `SBSP_BEAT_ONE)
		else $error("burst counter did not step");
	a_proc_ignored: assert property ( // RULE7
		(select_low_a_n && controller_addr_strobe_n) |=> $stable(selected) && $stable(addr_hi))
		else $error("processor strobe acted while first select high");
	a_proc_priority: assert property ( // RULE12
		(!processor_addr_strobe_n && !controller_addr_strobe_n && !select_low_a_n)
		|-> proc_load && !ctrl_load)
		else $error("controller strobe won over processor strobe");
	a_select_held: assert property ( // RULE9
		!load_go |=> selected == $past(selected))
		else $error("selection changed without an address load");
	a_first_masked: assert property ( // RULE11
		s_desel_then_read |=> !dq_oe)
		else $error("data driven on first read after deselect");
	a_drive_gate: assert property ( // RULE10 RULE14
		dq_oe |-> !pin_level[`SBSP_OE_BIT] && $past(read_beat) && $past(selected))
		else $error("data driven outside a read beat or with enable high");

endmodule

// file: verif/sbsp_bus_model.sv
`timescale 1ns/1ps
`include "sbsp_regs.svh"

module sbsp_bus_model (
	// Clock
	input  wire logic                    core_clk,
	// Device side of the data lines
	input  wire logic [`SBSP_DATA_W-1:0] dq_out,
	input  wire logic                    dq_oe,
	// Host side of the data lines
	input  wire logic                    host_drive,
	input  wire logic [`SBSP_DATA_W-1:0] host_data,
	output logic      [`SBSP_DATA_W-1:0] dq_in
);
	logic [`SBSP_DATA_W-1:0] last = `SBSP_DATA_RST;

	// A released line shows the inverse of its last level, so stale data never looks valid.
	always @(posedge core_clk) begin
		last <= dq_in;
	end

	always_comb begin
		if (dq_oe && host_drive) begin
			dq_in = {`SBSP_DATA_W{1'bx}};
		end else if (dq_oe) begin
			dq_in = dq_out;
		end else if (host_drive) begin
			dq_in = host_data;
		end else begin
			dq_in = ~last;
		end
	end
endmodule

// file: verif/sbsp_port_tb.sv
`timescale 1ns/1ps
`include "sbsp_regs.svh"

module sbsp_port_tb;
	import sbsp_pkg::*;
	typedef struct {int cyc; int code; logic [35:0] val;} sbsp_note_t;
	logic        core_clk, resetn, psn, csn, step, sa, sh, sb, qual, gw, oe_n, ord, host_drive;
	logic [18:0] address, mem_addr, last_a;
	logic [3:0]  lanes, mem_wr_lane;
	logic [35:0] dq_in, dq_out, mem_wdata, mem_rdata, host_data;
	logic        dq_oe, selected;
	int          cyc, checked, bad_count;
	logic [31:0] seed;
	sbsp_note_t  q[$];

	// ****************************************************************
	// Design, array and host model
	// ****************************************************************
	sbsp_port i_sbsp_port (.core_clk(core_clk), .resetn(resetn), .address(address),
		.processor_addr_strobe_n(psn), .controller_addr_strobe_n(csn), .burst_step_n(step),
		.select_low_a_n(sa), .select_high(sh), .select_low_b_n(sb), .byte_lane_write_n(lanes),
		.byte_write_qualifier_n(qual), .all_bytes_write_n(gw), .output_enable_n(oe_n),
		.burst_order(ord), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .mem_addr(mem_addr),
		.mem_wr_lane(mem_wr_lane), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.selected(selected));
	sbsp_bus_model i_sbsp_bus_model (.core_clk(core_clk), .dq_out(dq_out), .dq_oe(dq_oe),
		.host_drive(host_drive), .host_data(host_data), .dq_in(dq_in));
	assign mem_rdata = {mem_addr[16:0], mem_addr};

	always #4 core_clk = ~core_clk;

	task automatic check(logic [35:0] seen, logic [35:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic put(int off, int code, logic [35:0] v);
		q.push_back('{cyc + off, code, v});
	endtask

	task automatic give_verdict;
		if (q.size() != 0) bad_count++;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic idle;
		psn = 1'b1; csn = 1'b1; step = 1'b1; gw = 1'b1; qual = 1'b1; lanes = 4'hF;
		sa = 1'b0; sh = 1'b1; sb = 1'b0; host_drive = 1'b0;
	endtask

	// Every note due in this cycle is compared with the output it names.
	always @(negedge core_clk) begin
		for (int i = q.size() - 1; i >= 0; i--) begin
			if (q[i].cyc == cyc) begin
				case (q[i].code)
					0: check({17'h00000, mem_addr}, q[i].val);
					1: check({32'h00000000, mem_wr_lane}, q[i].val);
					2: check(mem_wdata, q[i].val);
					3: check(dq_out, q[i].val);
					4: check({35'h000000000, dq_oe}, q[i].val);
					default: check({35'h000000000, selected}, q[i].val);
				endcase
				q.delete(i);
			end
		end
	end

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 600) begin
			bad_count++;
			give_verdict();
		end
	end

	task automatic rd(logic order, logic oe);
		logic [18:0] a;
		logic [18:0] na;
		ord = order;
		oe_n = oe;
		repeat (4) @(negedge core_clk);
		a = 19'($random(seed));
		address = ~a; sh = 1'b0; csn = 1'b0;
		put(1, 5, 36'h000000000);
		put(2, 4, 36'h000000000);
		@(negedge core_clk);
		address = a; sh = 1'b1; csn = 1'b1; psn = 1'b0;
		put(1, 0, {17'h00000, a});
		put(1, 5, 36'h000000001);
		put(2, 3, {a[16:0], a});
		put(2, 4, 36'h000000000);
		for (int b = 1; b < 4; b++) begin
			@(negedge core_clk);
			psn = 1'b1; step = 1'b0;
			na = {a[18:2], order ? a[1:0] ^ 2'(b) : a[1:0] + 2'(b)};
			put(1, 0, {17'h00000, na});
			put(2, 3, {na[16:0], na});
			put(2, 4, {35'h000000000, ~oe});
		end
		@(negedge core_clk);
		idle();
		$display("test read order %0d oe_n %0d done", order, oe);
	endtask

	task automatic wr(logic gwv, logic qv);
		logic [3:0]  e;
		logic [35:0] d;
		last_a = 19'($random(seed));
		lanes = 4'($random(seed));
		d = {4'($random(seed)), 32'($random(seed))};
		address = last_a; csn = 1'b0; gw = gwv; qual = qv; host_drive = 1'b1; host_data = d;
		e = !gwv ? 4'hF : (!qv ? ~lanes : 4'h0);
		put(1, 1, {32'h00000000, e});
		if (e != 4'h0) put(1, 2, d);
		put(1, 0, {17'h00000, last_a});
		put(1, 4, 36'h000000000);
		@(negedge core_clk);
		idle();
		put(1, 1, 36'h000000000);
		@(negedge core_clk);
		$display("test write gw %0d qual %0d done", gwv, qv);
	endtask

	initial begin
		seed = 32'h2EE8F6FE;
		core_clk = 1'b0; resetn = 1'b0; oe_n = 1'b0; ord = 1'b0;
		address = 19'h00000; host_data = 36'h000000000;
		idle();
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		resetn = 1'b1;
		put(1, 5, 36'h000000000);
		put(1, 4, 36'h000000000);
		rd(1'b1, 1'b1);
		rd(1'b0, 1'b0);
		oe_n = 1'b1;
		repeat (4) @(negedge core_clk);
		for (int i = 0; i < 3; i++) wr(i != 0, i != 1);
		address = ~last_a; psn = 1'b0; sa = 1'b1; sh = 1'b0; step = 1'b0;
		put(1, 5, 36'h000000001);
		put(1, 0, {17'h00000, last_a[18:2], last_a[1:0] + 2'h1});
		@(negedge core_clk);
		psn = 1'b0; csn = 1'b0; sa = 1'b0; sh = 1'b1; step = 1'b1;
		put(1, 0, {17'h00000, ~last_a});
		put(1, 5, 36'h000000001);
		@(negedge core_clk);
		idle();
		$display("test ignored strobe and strobe priority done");
		repeat (4) @(negedge core_clk);
		give_verdict();
	end
endmodule
